/* verilog/memref_pkg.sv */
// Package for the memory-reference execution block: widths, fields,
// opcodes and the carrier structs shared by the executor and the sim files.
// Assumes a 12-bit word machine with a 4096-word memory.
package memref_pkg;

  localparam int WORD_W = 12;
  localparam int OFS_W  = 7;

  // Instruction field positions (bit 0 is the right-hand, low bit)
  localparam int OPC_HI  = 11;
  localparam int OPC_LO  = 9;
  localparam int IND_BIT = 8;
  localparam int PAGE_BIT = 7;
  localparam int OFS_HI  = 6;

  localparam logic [WORD_W-1:0] ZERO_WORD = 12'h000;
  localparam logic [WORD_W-1:0] ONE_WORD  = 12'h001;
  localparam logic [WORD_W-1:0] RESET_PC  = 12'h000;

  typedef enum logic [2:0] {
    and_op               = 3'h0,
    twos_add_op          = 3'h1,
    isz_op               = 3'h2,
    deposit_clear_acc_op = 3'h3,
    call_subroutine_op   = 3'h4,
    jump_op              = 3'h5,
    io_op                = 3'h6,
    operate_op           = 3'h7
  } opcode_t;

  // Memory request toward core memory
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;

  // Architectural state visible to the outside
  typedef struct packed {
    logic              link;
    logic [WORD_W-1:0] accumulator;
    logic [WORD_W-1:0] pc;
    logic [WORD_W-1:0] fetch_address_reg;
  } arch_state_t;

endpackage

/* verilog/memref_alu.sv */
// Combinational arithmetic and logic unit for the add and AND
// instructions. Assumes operands already latched by the caller.
`timescale 1ns/1ps
module memref_alu #(
  parameter int W = 12
) (
  input  wire logic [W-1:0] accumulator,
  input  wire logic         link,
  input  wire logic [W-1:0] memory_buffer,
  input  wire logic         do_add,
  output logic      [W-1:0] result,
  output logic              link_out
);

  logic [W:0] sum;

  always_comb begin
    sum = {1'b0, accumulator} + {1'b0, memory_buffer};
    if (do_add) begin
      result   = sum[W-1:0];
      link_out = link ^ sum[W];
    end else begin
      result   = accumulator & memory_buffer;
      link_out = link;
    end
  end

endmodule

/* verilog/memref_instruction_exec.sv */
// Memory-reference instruction executor: fetch sequencing, address
// modes, jump, call, deposit-clear, add and AND.
// Assumes a core memory that answers a read with valid data one
// cycle after mem_req.rd and accepts a write in the request cycle.
`timescale 1ns/1ps
module memref_instruction_exec #(
  parameter int W = memref_pkg::WORD_W
) (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic                    run,
  input  wire logic [W-1:0]            mem_rdata,
  output memref_pkg::mem_req_t         mem_req,
  output memref_pkg::arch_state_t      state,
  output logic                         fetch_strobe,
  output logic                         unsupported
);

  typedef enum logic [2:0] {
    st_idle,
    st_fetch,
    st_decode,
    st_defer,
    st_point,
    st_exec_rd,
    st_exec
  } phase_t;

  phase_t                     phase_r;
  logic [W-1:0]               pc_r;
  logic [W-1:0]               fetch_address_reg_r;
  logic [W-1:0]               accumulator_r;
  logic                       link_r;
  logic [W-1:0]               instr_r;
  logic [W-1:0]               ea_r;
  memref_pkg::mem_req_t       mem_req_r;
  logic                       fetch_strobe_r;
  logic                       unsupported_r;
  memref_pkg::opcode_t        opc;
  memref_pkg::opcode_t        fetched_opc;
  logic                       operand_op;
  logic [W-1:0]               direct_ea;
  logic [W-1:0]               alu_result;
  logic                       alu_link;

  assign mem_req      = mem_req_r;
  assign fetch_strobe = fetch_strobe_r;
  assign unsupported  = unsupported_r;
  assign state        = '{link: link_r, accumulator: accumulator_r,
                          pc: pc_r, fetch_address_reg: fetch_address_reg_r};

  assign opc = memref_pkg::opcode_t'(
                 instr_r[memref_pkg::OPC_HI:memref_pkg::OPC_LO]);

  // Opcode of the word on the bus in decode, before instr_r is loaded
  assign fetched_opc = memref_pkg::opcode_t'(
                 mem_rdata[memref_pkg::OPC_HI:memref_pkg::OPC_LO]);
  assign operand_op  = (opc == memref_pkg::and_op) ||
                       (opc == memref_pkg::twos_add_op);

  ////////////////////////////////////////////////////////////////////
  // Address formation

  always_comb begin
    if (mem_rdata[memref_pkg::PAGE_BIT]) begin
      direct_ea = {fetch_address_reg_r[W-1:memref_pkg::OFS_W],
                   mem_rdata[memref_pkg::OFS_HI:0]};
    end else begin
      direct_ea = {{(W-memref_pkg::OFS_W){1'b0}},
                   mem_rdata[memref_pkg::OFS_HI:0]};
    end
  end

  memref_alu #(
    .W (W)
  ) u_alu (
    .accumulator   (accumulator_r),
    .link          (link_r),
    .memory_buffer (mem_rdata),
    .do_add        (opc == memref_pkg::twos_add_op),
    .result        (alu_result),
    .link_out      (alu_link)
  );

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clock) begin
    if (reset) begin
      phase_r <= st_idle;
    end else begin
      unique case (phase_r)
        st_idle:    if (run) phase_r <= st_fetch;
        st_fetch:   phase_r <= st_decode;
        st_decode: begin
          // Non memory-reference opcodes are not executed here
          if (mem_rdata[memref_pkg::OPC_HI:memref_pkg::OPC_LO] >=
              3'(memref_pkg::io_op)) begin
            phase_r <= st_idle;
          end else if (mem_rdata[memref_pkg::IND_BIT]) begin
            phase_r <= st_defer;
          end else begin
            phase_r <= st_exec_rd;
          end
        end
        // Pointer word arrives the cycle after defer
        st_defer:   phase_r <= st_point;
        st_point:   phase_r <= st_exec_rd;
        st_exec_rd: phase_r <= st_exec;
        st_exec:    phase_r <= run ? st_fetch : st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Program counter and fetch address

  always_ff @(posedge clock) begin
    if (reset) begin
      pc_r                <= memref_pkg::RESET_PC + memref_pkg::ONE_WORD;
      fetch_address_reg_r <= memref_pkg::RESET_PC;
    end else if (phase_r == st_fetch) begin
      fetch_address_reg_r <= pc_r;
      pc_r                <= pc_r + memref_pkg::ONE_WORD;
    end else if (phase_r == st_exec_rd) begin
      // Fetch address tracks counter minus one to hold the offset
      unique case (opc)
        memref_pkg::jump_op: begin
          pc_r                <= ea_r;
          fetch_address_reg_r <= ea_r - memref_pkg::ONE_WORD;
        end
        memref_pkg::call_subroutine_op: begin
          pc_r                <= ea_r + memref_pkg::ONE_WORD;
          fetch_address_reg_r <= ea_r;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Instruction and effective address

  always_ff @(posedge clock) begin
    if (reset) begin
      instr_r         <= memref_pkg::ZERO_WORD;
      ea_r            <= memref_pkg::ZERO_WORD;
    end else begin
      if (phase_r == st_decode) begin
        instr_r <= mem_rdata;
        ea_r    <= direct_ea;
      end
      if (phase_r == st_point) begin
        ea_r <= mem_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Memory requests

  always_ff @(posedge clock) begin
    if (reset) begin
      mem_req_r <= '0;
    end else begin
      mem_req_r <= '0;
      unique case (phase_r)
        st_idle: begin
          if (run) begin
            mem_req_r.rd   <= 1'b1;
            mem_req_r.addr <= pc_r;
          end
        end
        st_exec: begin
          if (run) begin
            mem_req_r.rd   <= 1'b1;
            mem_req_r.addr <= pc_r;
          end
        end
        // Operand read leaves early so data stands in st_exec
        // add and AND only read
        st_decode: begin
          if ((fetched_opc < memref_pkg::io_op) &&
              (mem_rdata[memref_pkg::IND_BIT] ||
               fetched_opc == memref_pkg::and_op ||
               fetched_opc == memref_pkg::twos_add_op)) begin
            mem_req_r.rd   <= 1'b1;
            mem_req_r.addr <= direct_ea;
          end
        end
        st_defer: ;
        st_point: begin
          if (operand_op) begin
            mem_req_r.rd   <= 1'b1;
            mem_req_r.addr <= mem_rdata;
          end
        end
        st_fetch: ;
        st_exec_rd: begin
          unique case (opc)
            memref_pkg::deposit_clear_acc_op: begin
              mem_req_r.wr    <= 1'b1;
              mem_req_r.addr  <= ea_r;
              mem_req_r.wdata <= accumulator_r;
            end
            memref_pkg::call_subroutine_op: begin
              mem_req_r.wr    <= 1'b1;
              mem_req_r.addr  <= ea_r;
              mem_req_r.wdata <= pc_r;
            end
            default: ;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Accumulator and link

  always_ff @(posedge clock) begin
    if (reset) begin
      accumulator_r <= memref_pkg::ZERO_WORD;
      link_r        <= 1'b0;
    end else if (phase_r == st_exec) begin
      unique case (opc)
        memref_pkg::and_op, memref_pkg::twos_add_op: begin
          accumulator_r <= alu_result;
          link_r        <= alu_link;
        end
        memref_pkg::deposit_clear_acc_op: begin
          accumulator_r <= memref_pkg::ZERO_WORD;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status pulses

  always_ff @(posedge clock) begin
    if (reset) begin
      fetch_strobe_r <= 1'b0;
      unsupported_r  <= 1'b0;
    end else begin
      fetch_strobe_r <= (phase_r == st_fetch);
      unsupported_r  <= (phase_r == st_decode) &&
                        (mem_rdata[memref_pkg::OPC_HI:memref_pkg::OPC_LO]
                         >= 3'(memref_pkg::io_op));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  // Counter stays one above the fetch address outside st_fetch
  property counter_ahead_p;
    @(posedge clock) disable iff (reset)
      (phase_r != st_fetch) |->
        (pc_r == fetch_address_reg_r + memref_pkg::ONE_WORD);
  endproperty
  counter_ahead_a: assert property (counter_ahead_p)
    else $error("counter not one above fetch address");

  fetch_incr_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_fetch) |=> (fetch_address_reg_r == $past(pc_r)) &&
      (pc_r == $past(pc_r) + memref_pkg::ONE_WORD))
    else $error("fetch did not copy and increment");

  deposit_clear_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_exec_rd && opc == memref_pkg::deposit_clear_acc_op)
      |=> mem_req_r.wr && mem_req_r.wdata == $past(accumulator_r)
      ##0 1'b1 ##1 accumulator_r == memref_pkg::ZERO_WORD)
    else $error("deposit did not store then clear");

  deposit_link_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_exec && opc == memref_pkg::deposit_clear_acc_op)
      |=> $stable(link_r))
    else $error("deposit changed link");

  jump_target_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_exec_rd && opc == memref_pkg::jump_op)
      |=> pc_r == $past(ea_r))
    else $error("jump target not loaded");

  jump_keeps_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_exec && opc == memref_pkg::jump_op)
      |=> $stable(accumulator_r) && $stable(link_r))
    else $error("jump changed accumulator or link");

  call_store_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_exec_rd && opc == memref_pkg::call_subroutine_op)
      |=> mem_req_r.wr && mem_req_r.wdata == $past(pc_r) &&
      pc_r == $past(ea_r) + memref_pkg::ONE_WORD)
    else $error("call did not store return and jump");

  add_result_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_exec && opc == memref_pkg::twos_add_op)
      |=> accumulator_r == W'($past(accumulator_r) + $past(mem_rdata))
      && link_r == ($past(link_r) ^ (({1'b0, $past(accumulator_r)} +
      {1'b0, $past(mem_rdata)}) >> W)))
    else $error("add result or link wrong");

  read_only_a: assert property (@(posedge clock) disable iff (reset)
    (phase_r == st_exec_rd && (opc == memref_pkg::and_op ||
      opc == memref_pkg::twos_add_op)) |=> !mem_req_r.wr)
    else $error("add or AND wrote memory");

  cover_call_c: cover property (@(posedge clock)
    phase_r == st_exec && opc == memref_pkg::call_subroutine_op);
  cover_ind_jump_c: cover property (@(posedge clock)
    phase_r == st_defer ##2 opc == memref_pkg::jump_op);
  cover_add_carry_c: cover property (@(posedge clock)
    phase_r == st_exec && opc == memref_pkg::twos_add_op
    && ({1'b0, accumulator_r} + {1'b0, mem_rdata}) >> W != 0);

endmodule

/* sim/core_mem_model.sv */
// Behavioural core memory facing the instruction executor.
// Assumes one clock; read data shows the cycle after a read request.
`timescale 1ns/1ps
module core_mem_model (
  input  wire logic                  clock,
  input  wire memref_pkg::mem_req_t  mem_req,
  output logic [11:0]                mem_rdata
);
  logic [11:0] mem [0:4095];
  logic [11:0] rdata_r;

  initial begin
    rdata_r = 12'h000;
    for (int i = 0; i < 4096; i++) mem[i] = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outside the answer cycle the data lines flip, so stale data is never held
  // Plain always: the bench preloads words by hierarchical writes
  always @(posedge clock) begin
    if (mem_req.rd) begin
      rdata_r <= mem[mem_req.addr];
    end else begin
      rdata_r <= ~rdata_r;
    end
    if (mem_req.wr) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end

  assign mem_rdata = rdata_r;
endmodule

/* sim/memref_instruction_exec_tb.sv */
// Self-checking bench for the memory-reference executor.
// Assumes core_mem_model as the far side; programs loaded directly.
`timescale 1ns/1ps
module memref_instruction_exec_tb;
  logic                    clock = 1'b0;
  logic                    reset = 1'b1;
  logic                    run   = 1'b0;
  logic [11:0]             mem_rdata;
  memref_pkg::mem_req_t    mem_req;
  memref_pkg::arch_state_t state;
  logic                    fetch_strobe;
  logic                    unsupported;
  int                      n_fail = 0;
  int                      checked = 0;
  int                      cycles = 0;
  int                      ntr = 0;
  int                      n_uns = 0;
  logic [11:0]             tr_far [0:15];
  logic [11:0]             tr_acc [0:15];
  logic                    tr_link [0:15];

  always #5 clock = ~clock;

  memref_instruction_exec uut (
    .clock(clock), .reset(reset), .run(run), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .state(state), .fetch_strobe(fetch_strobe),
    .unsupported(unsupported));

  core_mem_model mem_u (.clock(clock), .mem_req(mem_req),
    .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] seen,
                     input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  // Trace taken at negedge so the design's edge updates have landed
  always @(negedge clock) begin
    if (!reset && fetch_strobe === 1'b1 && ntr < 16) begin
      tr_far[ntr] = state.fetch_address_reg;
      tr_acc[ntr] = state.accumulator;
      tr_link[ntr] = state.link;
      ntr++;
      chk("pc", state.pc, state.fetch_address_reg + 12'h001);
    end
    if (!reset && unsupported === 1'b1) n_uns++;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] mk(input logic [2:0] op, input logic ind,
                                     input logic cur, input logic [6:0] o);
    return {op, ind, cur, o};
  endfunction

  task automatic do_reset;
    @(posedge clock);
    #1 reset = 1'b1;
    run = 1'b0;
    repeat (6) @(posedge clock);
    #1 reset = 1'b0;
    ntr = 0;
    n_uns = 0;
  endtask

  // Raise run and wait for n fetches, bounded
  task automatic go(input int n);
    run = 1'b1;
    for (int i = 0; i < 600 && ntr < n; i++) @(posedge clock);
    chk("fetches", 12'(ntr >= n), 12'h001);
    @(posedge clock);
    #1 run = 1'b0;
    repeat (8) @(posedge clock);
  endtask

  task automatic step(input int i, input logic [11:0] far,
                      input logic [11:0] acc, input logic lnk);
    chk("fetch addr", tr_far[i], far);
    chk("acc", tr_acc[i], acc);
    chk("link", 12'(tr_link[i]), 12'(lnk));
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    do_reset();
    #1;
    chk("reset pc", state.pc, 12'h001);
    chk("reset far", state.fetch_address_reg, 12'h000);
    chk("reset acc", state.accumulator, 12'h000);
    chk("reset link", 12'(state.link), 12'h000);
    $display("test reset done");
  endtask

  // Add with one carry, AND, deposit; link toggles and survives
  task automatic t_arith;
    do_reset();
    mem_u.mem[12'h001] = mk(memref_pkg::twos_add_op, 0, 0, 7'h40);
    mem_u.mem[12'h002] = mk(memref_pkg::twos_add_op, 0, 0, 7'h41);
    mem_u.mem[12'h003] = mk(memref_pkg::twos_add_op, 0, 0, 7'h43);
    mem_u.mem[12'h004] = mk(memref_pkg::and_op, 0, 0, 7'h44);
    mem_u.mem[12'h005] = mk(memref_pkg::deposit_clear_acc_op, 0, 0, 7'h45);
    mem_u.mem[12'h006] = mk(memref_pkg::jump_op, 0, 0, 7'h06);
    mem_u.mem[12'h040] = 12'hfff;
    mem_u.mem[12'h041] = 12'h001;
    mem_u.mem[12'h043] = 12'ha5c;
    mem_u.mem[12'h044] = 12'h0f0;
    mem_u.mem[12'h045] = 12'h777;
    go(7);
    step(0, 12'h001, 12'h000, 0);
    step(1, 12'h002, 12'hfff, 0);
    step(2, 12'h003, 12'h000, 1);
    step(3, 12'h004, 12'ha5c, 1);
    step(4, 12'h005, 12'h050, 1);
    step(5, 12'h006, 12'h000, 1);
    step(6, 12'h006, 12'h000, 1);
    chk("mem40", mem_u.mem[12'h040], 12'hfff);
    chk("mem41", mem_u.mem[12'h041], 12'h001);
    chk("mem44", mem_u.mem[12'h044], 12'h0f0);
    chk("mem45", mem_u.mem[12'h045], 12'h050);
    $display("test arith done");
  endtask

  // Call, return, indirect jumps, current page and indirect deposit
  task automatic t_ctrl;
    do_reset();
    mem_u.mem[12'h001] = mk(memref_pkg::call_subroutine_op, 0, 0, 7'h50);
    mem_u.mem[12'h051] = mk(memref_pkg::jump_op, 1, 0, 7'h50);
    mem_u.mem[12'h002] = mk(memref_pkg::jump_op, 1, 0, 7'h60);
    mem_u.mem[12'h060] = 12'h345;
    mem_u.mem[12'h345] = mk(memref_pkg::twos_add_op, 0, 1, 7'h10);
    mem_u.mem[12'h310] = 12'h123;
    mem_u.mem[12'h346] = mk(memref_pkg::call_subroutine_op, 1, 0, 7'h61);
    mem_u.mem[12'h061] = 12'h700;
    mem_u.mem[12'h701] = mk(memref_pkg::deposit_clear_acc_op, 1, 0, 7'h62);
    mem_u.mem[12'h062] = 12'h7ff;
    mem_u.mem[12'h702] = mk(memref_pkg::jump_op, 0, 1, 7'h02);
    go(8);
    step(0, 12'h001, 12'h000, 0);
    step(1, 12'h051, 12'h000, 0);
    step(2, 12'h002, 12'h000, 0);
    step(3, 12'h345, 12'h000, 0);
    step(4, 12'h346, 12'h123, 0);
    step(5, 12'h701, 12'h123, 0);
    step(6, 12'h702, 12'h000, 0);
    step(7, 12'h702, 12'h000, 0);
    chk("ret addr", mem_u.mem[12'h050], 12'h002);
    chk("ret addr2", mem_u.mem[12'h700], 12'h347);
    chk("ind store", mem_u.mem[12'h7ff], 12'h123);
    $display("test control done");
  endtask

  // Opcodes outside this block are refused, then flow continues
  task automatic t_refuse;
    do_reset();
    mem_u.mem[12'h001] = 12'hc00;
    mem_u.mem[12'h002] = 12'he00;
    mem_u.mem[12'h003] = mk(memref_pkg::jump_op, 0, 0, 7'h03);
    go(4);
    step(0, 12'h001, 12'h000, 0);
    step(1, 12'h002, 12'h000, 0);
    step(2, 12'h003, 12'h000, 0);
    chk("refusals", 12'(n_uns), 12'h002);
    $display("test refuse done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset();
    t_arith();
    t_ctrl();
    t_refuse();
    test_done();
  end
endmodule
